// >>> logic/pcps_pin_select.sv
// Pin function selector for panel, CRT, expansion card and clock inputs.
// Operation
// - Unused panel data pins are driven low.
// - Active panels put display enable on multi-pin.
// - Format one passive panels put second shift clock.
// - Other panels put backplane bias on multi-pin.
// - Upper data byte moves to card by strap.
// - Bit nine is data or card control.
// - Bits ten to thirteen: data or card bus.
// - Multi-pin becomes card power enable by strap.
// - Retrace outputs are held low during reset.
// - Clock A feeds pixel, memory and card clocks.
// - Clock B feeds only pixel and card clocks.
// - Strap bus latched at reset release.
`timescale 1ns/10ps
`default_nettype none

module pcps_pin_select
  import pcps_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [PCPS_STRAP_W-1:0] config_strap_bus,
  input wire pcps_panel_type panel_type,
  input wire logic timing_en,
  input wire pcps_timing_type timing,
  input wire logic [PCPS_DATA_W-1:0] pixel_data,
  input wire logic [PCPS_DATA_W-1:0] data_mask,
  input wire logic hretrace_in,
  input wire logic vretrace_in,
  input wire logic card_ctl_in,
  input wire logic [PCPS_CARD_DATA_W-1:0] card_data_wr,
  input wire logic card_data_drive,
  input wire logic card_power_in,
  input wire logic [PCPS_CARD_DATA_W-1:0] card_data_pin_i,
  input wire logic clock_input_a,
  input wire logic clock_input_b,
  input wire pcps_clk_src_type pixel_clk_sel,
  input wire pcps_clk_src_type card_clk_sel,
  output logic [PCPS_DATA_W-1:0] panel_data,
  output logic [PCPS_DATA_W-1:0] panel_data_oe_n,
  output logic frame_pulse_out,
  output logic line_pulse_out,
  output logic panel_shift_clock,
  output logic multi_pin_out,
  output logic horizontal_retrace,
  output logic vertical_retrace,
  output logic pixel_clock,
  output logic memory_clock,
  output logic card_clock,
  output logic [PCPS_CARD_DATA_W-1:0] card_data_rd,
  output pcps_strap_type strap_q
);

  // Two-stage synchronisers for the strap bus, the two clock inputs and the card data pins.
  logic [PCPS_STRAP_W-1:0] strap_s1_q;
  logic [PCPS_STRAP_W-1:0] strap_s2_q;
  logic [1:0] clk_s1_q;
  logic [1:0] clk_s2_q;
  logic [PCPS_CARD_DATA_W-1:0] cd_s1_q;
  logic [PCPS_CARD_DATA_W-1:0] cd_s2_q;

  // Only the second stages are read below.
  always_ff @(posedge clk) begin
    strap_s1_q <= config_strap_bus;
    strap_s2_q <= strap_s1_q;
    clk_s1_q <= {clock_input_b, clock_input_a};
    clk_s2_q <= clk_s1_q;
    cd_s1_q <= card_data_pin_i;
    cd_s2_q <= cd_s1_q;
  end

  // The straps follow the bus while reset stands, so the value seen on the
  // last reset cycle is the one held afterwards.
  pcps_strap_type strap_d;
  assign strap_d = rst ? pcps_strap_type'{card_bus: strap_s2_q[PCPS_STRAP_CARD_BUS_BIT],
                                          card_power: strap_s2_q[PCPS_STRAP_CARD_POWER_BIT]}
                       : strap_q;

  always_ff @(posedge clk) begin
    strap_q <= strap_d;
  end

  // Clock routing; the memory clock has no path from clock B.
  logic clk_a;
  logic clk_b;
  logic pixel_clock_d;
  logic card_clock_d;
  assign clk_a = clk_s2_q[0];
  assign clk_b = clk_s2_q[1];
  assign pixel_clock_d = (pixel_clk_sel == PCPS_CLK_B) ? clk_b : clk_a;
  assign card_clock_d = (card_clk_sel == PCPS_CLK_B) ? clk_b : clk_a;

  // Multi-function control pin selection.
  logic display_enable_out;
  logic second_shift_clock;
  logic backplane_bias;
  logic panel_fn;
  logic multi_d;
  assign display_enable_out = timing.enable;
  assign second_shift_clock = timing.shift2;
  assign backplane_bias = timing.bias;
  assign panel_fn = (panel_type == PCPS_PANEL_ACTIVE) ? display_enable_out :
                    (panel_type == PCPS_PANEL_FMT1) ? second_shift_clock :
                    backplane_bias;
  assign multi_d = strap_q.card_power ? (rst | card_power_in)
                                      : (~rst & panel_fn);

  // Panel data and card remapping of the upper byte. Bits 15:14 go low in
  // card mode because the card uses only the clock, control and data pins.
  logic [PCPS_DATA_W-1:0] panel_val;
  logic [PCPS_DATA_W-1:0] card_val;
  logic [PCPS_DATA_W-1:0] data_d;
  logic [PCPS_DATA_W-1:0] oe_n_d;
  logic card_hiz;
  assign panel_val = pixel_data & data_mask;
  assign card_val = {2'b00, card_data_wr, card_ctl_in, card_clock_d, panel_val[7:0]};
  assign data_d = rst ? PCPS_DATA_RESET : (strap_q.card_bus ? card_val : panel_val);
  assign card_hiz = rst | ~card_data_drive;
  assign oe_n_d = strap_q.card_bus ? {2'b00, {PCPS_CARD_DATA_W{card_hiz}}, rst, 9'h000}
                                   : PCPS_OE_N_RESET;

  // Timing outputs stay quiet until the panel timing is running.
  logic timing_on;
  assign timing_on = ~rst & timing_en;

  // All outputs except strap_q come from this one register stage.
  always_ff @(posedge clk) begin
    panel_data <= data_d;
    panel_data_oe_n <= oe_n_d;
    multi_pin_out <= multi_d;
    frame_pulse_out <= timing_on & timing.frame;
    line_pulse_out <= timing_on & timing.line;
    panel_shift_clock <= timing_on & timing.shift;
    horizontal_retrace <= ~rst & hretrace_in;
    vertical_retrace <= ~rst & vretrace_in;
    pixel_clock <= pixel_clock_d;
    memory_clock <= clk_a;
    card_clock <= card_clock_d;
    card_data_rd <= rst ? PCPS_CARD_DATA_RESET : cd_s2_q;
  end

  // Checks on the pin decisions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_unused_low;
    !strap_q.card_bus |=> ((panel_data & ~$past(data_mask)) == PCPS_DATA_RESET);
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("unused data pin not low");

  property p_active_enable;
    (!strap_q.card_power && panel_type == PCPS_PANEL_ACTIVE) |=>
      multi_pin_out == $past(timing.enable);
  endproperty
  a_active_enable: assert property (p_active_enable) else $error("display enable missing");

  property p_fmt1_shift2;
    (!strap_q.card_power && panel_type == PCPS_PANEL_FMT1) |=>
      multi_pin_out == $past(timing.shift2);
  endproperty
  a_fmt1_shift2: assert property (p_fmt1_shift2) else $error("second shift clock missing");

  property p_other_bias;
    (!strap_q.card_power && panel_type == PCPS_PANEL_OTHER) |=>
      multi_pin_out == $past(timing.bias);
  endproperty
  a_other_bias: assert property (p_other_bias) else $error("backplane bias missing");

  property p_card_byte;
    strap_q.card_bus |=> panel_data[13:9] == {$past(card_data_wr), $past(card_ctl_in)}
                         && panel_data[15:14] == 2'b00;
  endproperty
  a_card_byte: assert property (p_card_byte) else $error("card byte not routed");

  property p_reset_release;
    $past(rst) |-> (panel_data == PCPS_DATA_RESET) && !horizontal_retrace && !vertical_retrace
                   && (strap_q.card_power ? multi_pin_out : !multi_pin_out)
                   && (strap_q.card_bus ? panel_data_oe_n[13:9] == 5'h1f
                                        : panel_data_oe_n == PCPS_OE_N_RESET);
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset pin state wrong");

  property p_power_follow;
    strap_q.card_power |=> multi_pin_out == $past(card_power_in);
  endproperty
  a_power_follow: assert property (p_power_follow) else $error("card power not routed");

  // Two synchroniser stages and the output register make three cycles of lag.
  property p_memory_clock;
    1'b1 |=> memory_clock == $past(clock_input_a, 3);
  endproperty
  a_memory_clock: assert property (p_memory_clock) else $error("memory clock not from A");

  property p_strap_hold;
    !rst |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("straps changed after reset");

  property p_timing_quiet;
    !timing_en |=> !frame_pulse_out && !line_pulse_out && !panel_shift_clock;
  endproperty
  a_timing_quiet: assert property (p_timing_quiet) else $error("timing active while off");

  c_card_mode: cover property (strap_q.card_bus && card_data_drive);
  c_power_mode: cover property (strap_q.card_power && multi_pin_out);
  c_fmt1_panel: cover property (panel_type == PCPS_PANEL_FMT1 && multi_pin_out);
  c_clock_b: cover property (pixel_clk_sel == PCPS_CLK_B && pixel_clock);

endmodule : pcps_pin_select

`default_nettype wire

// >>> include/pcps_pkg.sv
// Shared constants and types for the panel and CRT pin function selector.
package pcps_pkg;

  // Pin bus widths.
  localparam int unsigned PCPS_DATA_W = 16;
  localparam int unsigned PCPS_STRAP_W = 16;
  localparam int unsigned PCPS_CARD_DATA_W = 4;

  // Strap bit positions on the configuration strap bus.
  localparam int unsigned PCPS_STRAP_CARD_BUS_BIT = 12;
  localparam int unsigned PCPS_STRAP_CARD_POWER_BIT = 13;

  // Reset values of the driven pins.
  localparam logic [15:0] PCPS_DATA_RESET = 16'h0000;
  localparam logic [15:0] PCPS_OE_N_RESET = 16'h0000;
  localparam logic [3:0] PCPS_CARD_DATA_RESET = 4'h0;

  // Panel families that decide the multi-function control pin.
  typedef enum logic [1:0] {
    PCPS_PANEL_ACTIVE,
    PCPS_PANEL_FMT1,
    PCPS_PANEL_OTHER
  } pcps_panel_type;

  // Clock source choice.
  typedef enum logic {
    PCPS_CLK_A,
    PCPS_CLK_B
  } pcps_clk_src_type;

  // Panel timing signals from the display pipeline.
  typedef struct packed {
    logic frame;
    logic line;
    logic shift;
    logic shift2;
    logic enable;
    logic bias;
  } pcps_timing_type;

  // Latched strap decisions.
  typedef struct packed {
    logic card_bus;
    logic card_power;
  } pcps_strap_type;

endpackage : pcps_pkg

// >>> verif/pcps_card_model.sv
// Far-side expansion card model that resolves the shared card data pins.
`timescale 1ns/10ps
`default_nettype none
module pcps_card_model
  import pcps_pkg::*;
(
  input wire logic clk,
  input wire logic [PCPS_CARD_DATA_W-1:0] pin_out,
  input wire logic [PCPS_CARD_DATA_W-1:0] pin_oe_n,
  input wire logic card_drive,
  input wire logic [PCPS_CARD_DATA_W-1:0] card_value,
  output logic [PCPS_CARD_DATA_W-1:0] pin_level
);
  logic [PCPS_CARD_DATA_W-1:0] last_q = 4'h0;
  // A floating wire shows the inverse of its last level, so stale data never reads as fresh.
  always_comb begin
    for (int i = 0; i < PCPS_CARD_DATA_W; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (card_drive) pin_level[i] = card_value[i];
      else pin_level[i] = ~last_q[i];
    end
  end
  // Remember the last driven level.
  always @(posedge clk) if (card_drive || !(&pin_oe_n)) last_q <= pin_level;
endmodule : pcps_card_model
`default_nettype wire

// >>> verif/test_pcps_pin_select.sv
// Self-checking bench for the panel and CRT pin function selector.
`timescale 1ns/10ps
`default_nettype none
module test_pcps_pin_select;
  import pcps_pkg::*;
  logic clk = 0, rst = 1, ten = 0, hr = 0, vr = 0, cctl = 0, cdrv = 0, cpow = 0;
  logic ca = 0, cb = 0, crun = 0, con = 0, fr, ln, sh, mp, hro, vro, pclk, mclk, cclk;
  logic [15:0] strap = 16'h0000, pix = 16'h0000, mask = 16'h0000, pd, oen;
  logic [3:0] cwr = 4'h0, cval = 4'h0, crd, pin;
  pcps_panel_type ptype = PCPS_PANEL_OTHER;
  pcps_timing_type tim = '0;
  pcps_clk_src_type psel = PCPS_CLK_A, csel = PCPS_CLK_A;
  pcps_strap_type sq;
  integer err_count = 0, checked = 0, cycles = 0, rises;
  pcps_pin_select pcps_pin_select_inst (.clk(clk), .rst(rst), .config_strap_bus(strap),
    .panel_type(ptype), .timing_en(ten), .timing(tim), .pixel_data(pix), .data_mask(mask),
    .hretrace_in(hr), .vretrace_in(vr), .card_ctl_in(cctl), .card_data_wr(cwr),
    .card_data_drive(cdrv), .card_power_in(cpow), .card_data_pin_i(pin),
    .clock_input_a(ca), .clock_input_b(cb), .pixel_clk_sel(psel), .card_clk_sel(csel),
    .panel_data(pd), .panel_data_oe_n(oen), .frame_pulse_out(fr), .line_pulse_out(ln),
    .panel_shift_clock(sh), .multi_pin_out(mp), .horizontal_retrace(hro),
    .vertical_retrace(vro), .pixel_clock(pclk), .memory_clock(mclk), .card_clock(cclk),
    .card_data_rd(crd), .strap_q(sq));
  pcps_card_model pcps_card_model_inst (.clk(clk), .pin_out(pd[13:10]),
    .pin_oe_n(oen[13:10]), .card_drive(con), .card_value(cval), .pin_level(pin));
  // System clock, and a 400 ns link clock that runs only while a test wants it.
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    #37;
    forever #200 if (crun) ca = ~ca;
  end
  // A hang is cut short here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  // Reset with busy inputs, so held-low outputs are really forced low.
  task automatic do_reset(input logic [15:0] s);
    strap = s; rst = 1; ten = 1; tim = '1; hr = 1; vr = 1; pix = 16'hffff; mask = 16'hffff;
    step(19);
    chk(pd, 16'h0000);
    chk({fr, ln, sh, hro, vro}, 16'h0000);
    chk(mp, s[13]);
    chk(oen, s[12] ? 16'h3e00 : 16'h0000);
    step(1);
    rst = 0;
    step(1);
    chk(sq, {s[12], s[13]});
  endtask : do_reset
  // Each panel family picks its own source for the multi-function pin.
  task automatic panel_modes();
    logic [5:0] want;
    for (int t = 0; t < 3; t++) begin
      ptype = pcps_panel_type'(t);
      want = (t == 0) ? 6'h02 : (t == 1) ? 6'h04 : 6'h01;
      tim = want;
      step(1);
      chk(mp, 1'b1);
      tim = ~want;
      step(1);
      chk(mp, 1'b0);
    end
    pix = 16'ha5c3; mask = 16'h0ff0; hr = 1; vr = 0;
    step(1);
    chk(pd, 16'h05c0);
    chk({hro, vro}, 2'b10);
    ten = 0; tim = 6'h38;
    step(1);
    chk({fr, ln, sh}, 3'b000);
    ten = 1;
    step(1);
    chk({fr, ln, sh}, 3'b111);
  endtask : panel_modes
  // Clock routing; clock B must never reach the memory clock.
  task automatic clock_routes();
    logic prev;
    psel = PCPS_CLK_B; ca = 1; cb = 0;
    step(3);
    chk({pclk, mclk, cclk}, 3'b011);
    ca = 0; cb = 1;
    step(3);
    chk({pclk, mclk, cclk}, 3'b100);
    psel = PCPS_CLK_A; csel = PCPS_CLK_B;
    step(1);
    chk({pclk, mclk, cclk}, 3'b001);
    crun = 1; rises = 0; prev = mclk;
    // The previous level is kept by hand, so every rise is counted once.
    repeat (40) begin
      step(1);
      if (mclk === 1'b1 && prev === 1'b0) rises++;
      prev = mclk;
    end
    crun = 0;
    chk(16'(rises), 16'h0005);
  endtask : clock_routes
  // Card mode: upper byte and multi-pin move to the expansion card.
  task automatic card_mode();
    do_reset(16'h3000);
    cctl = 1; cwr = 4'h9; cdrv = 1; cpow = 0;
    step(1);
    chk({pd[15:14], pd[13:9]}, {2'b00, 4'h9, 1'b1});
    chk(pd[8], 1'b1);
    chk(mp, 1'b0);
    cdrv = 0; con = 1; cval = 4'h6; cpow = 1;
    step(4);
    chk(oen[13:10], 4'hf);
    chk(crd, 4'h6);
    chk(mp, 1'b1);
  endtask : card_mode
  task automatic report_and_stop();
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  // Main sequence.
  initial begin
    do_reset(16'h0000);
    chk(oen, 16'h0000);
    panel_modes();
    clock_routes();
    card_mode();
    report_and_stop();
  end
endmodule : test_pcps_pin_select
`default_nettype wire
